// [common/uar_pkg.sv]
// constants, field layouts and types of the async receive path
// assumes registers sit on APB, one aligned word per register index
package uar_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] UAR_IDX_FLAGS = 10'h00C;
  localparam logic [9:0] UAR_IDX_RCS = 10'h018;
  localparam logic [9:0] UAR_IDX_TXB = 10'h019;
  localparam logic [9:0] UAR_IDX_RXD = 10'h01A;
  localparam logic [9:0] UAR_IDX_IEN = 10'h08C;
  localparam logic [9:0] UAR_IDX_TXS = 10'h098;
  localparam logic [9:0] UAR_IDX_BAUD = 10'h099;
  // bit positions
  localparam int UAR_B_READY = 5;
  localparam int UAR_B_RSVD = 6;
  localparam int UAR_B_SERIAL_PORT_ENABLE = 7;
  localparam int UAR_B_RX9 = 6;
  localparam int UAR_B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int UAR_B_FRAMING_ERROR = 2;
  localparam int UAR_B_OVERRUN_ERROR = 1;
  localparam int UAR_B_RECEIVED_NINTH_BIT = 0;
  localparam int UAR_B_CLOCK_SOURCE_SELECT = 7;
  localparam int UAR_B_TXEN = 5;
  localparam int UAR_B_SYNC = 4;
  localparam int UAR_B_SREN = 5;
  localparam int UAR_B_HIGH_SPEED_BAUD_SELECT = 2;
  // reset values and software write masks
  localparam logic [7:0] UAR_RST_FLAGS = 8'h00;
  localparam logic [7:0] UAR_RST_RCS = 8'h00;
  localparam logic [7:0] UAR_RST_TXB = 8'h00;
  localparam logic [7:0] UAR_RST_IEN = 8'h00;
  localparam logic [7:0] UAR_RST_TXS = 8'h02;
  localparam logic [7:0] UAR_RST_BAUD = 8'h00;
  localparam logic [7:0] UAR_WM_FLAGS = 8'h9F;
  localparam logic [7:0] UAR_WM_RCS = 8'hF0;
  localparam logic [7:0] UAR_WM_IEN = 8'hBF;
  localparam logic [7:0] UAR_WM_TXS = 8'hF5;
  // oversampling timing in sample ticks within one bit, low speed prescale step and last data bit index
  localparam logic [3:0] UAR_SMP_A = 4'h6;
  localparam logic [3:0] UAR_SMP_B = 4'h7;
  localparam logic [3:0] UAR_SMP_C = 4'h8;
  localparam logic [3:0] UAR_LAST = 4'hF;
  localparam logic [1:0] UAR_LOW_PRE = 2'h3;
  localparam logic [3:0] UAR_BITS8 = 4'h7;
  localparam logic [3:0] UAR_BITS9 = 4'h8;
  typedef struct packed {
    logic framing_error;
    logic ninth;
    logic [7:0] data;
  } uar_entry_t;
  typedef enum logic [1:0] {
    UAR_IDLE = 2'b00,
    UAR_START = 2'b01,
    UAR_DATA = 2'b10,
    UAR_STOP = 2'b11
  } uar_state_t;
endpackage

// [src/uar_receiver.sv]
// async receive path with APB register file, baud generator and fifo
// assumes APB master in clk_sys domain and rx input synchronous to it
`timescale 1ns/1ps
`default_nettype none
module uar_receiver
  import uar_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_in,
  input wire logic tx_serial_data,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe_n,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n,
  output logic receive_irq
);
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // refuse depths the pointer wrap cannot serve
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_chk
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] nw,
                                     input logic [7:0] m);
    wr8 = (old & ~m) | (nw & m);
  endfunction

  logic [7:0] flags_q, rcs_q, txb_q, ien_q, txs_q, baud_q;
  logic [31:0] prdata_q;
  uar_entry_t mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wptr_q, rptr_q;
  logic [PTR_W:0] count_q;
  uar_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d, bit_q, bit_d;
  logic [8:0] sr_q, sr_d;
  logic [1:0] s_q, s_d;
  logic rx_prev_q, overrun_error_q;
  logic [7:0] gen_q;
  logic [1:0] pre_q;
  logic [3:0] sck_q;
  logic sck_out_q, dt_out_q;

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire [9:0] idx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_flags = aligned & (idx == UAR_IDX_FLAGS);
  wire hit_rcs = aligned & (idx == UAR_IDX_RCS);
  wire hit_txb = aligned & (idx == UAR_IDX_TXB);
  wire hit_rxd = aligned & (idx == UAR_IDX_RXD);
  wire hit_ien = aligned & (idx == UAR_IDX_IEN);
  wire hit_txs = aligned & (idx == UAR_IDX_TXS);
  wire hit_baud = aligned & (idx == UAR_IDX_BAUD);
  wire hit = hit_flags | hit_rcs | hit_txb | hit_rxd | hit_ien | hit_txs | hit_baud;
  wire wr_en = access & pwrite & hit;
  wire rd_fifo = access & ~pwrite & hit_rxd;

  // mode and enable fields
  wire serial_port_enable = rcs_q[UAR_B_SERIAL_PORT_ENABLE];
  wire continuous_receive_enable = rcs_q[UAR_B_CONTINUOUS_RECEIVE_ENABLE];
  wire rx9 = rcs_q[UAR_B_RX9];
  wire sren = rcs_q[UAR_B_SREN];
  wire sync_mode = txs_q[UAR_B_SYNC];
  wire clock_source_select = txs_q[UAR_B_CLOCK_SOURCE_SELECT];
  wire txen = txs_q[UAR_B_TXEN];
  wire high_speed_baud_select = txs_q[UAR_B_HIGH_SPEED_BAUD_SELECT];
  wire rx_run = serial_port_enable & continuous_receive_enable & ~sync_mode;

  // fifo status and head entry
  wire fifo_empty = (count_q == '0);
  wire fifo_full = (count_q == (PTR_W + 1)'(FIFO_DEPTH));
  wire pop = rd_fifo & ~fifo_empty;
  uar_entry_t head;
  // empty fifo shows zero status and data, never a stale or unwritten entry
  assign head = fifo_empty ? '0 : mem[rptr_q];
  wire ready_flag = ~fifo_empty;

  // read view of every register
  wire [7:0] flags_rd = (flags_q & UAR_WM_FLAGS) | {2'b00, ready_flag, 5'b00000};
  wire [7:0] rcs_rd = {rcs_q[7:4], 1'b0, head.framing_error, overrun_error_q, head.ninth};
  wire [7:0] rd_value = hit_flags ? flags_rd :
                        hit_rcs ? rcs_rd :
                        hit_txb ? txb_q :
                        hit_rxd ? head.data :
                        hit_ien ? (ien_q & UAR_WM_IEN) :
                        hit_txs ? txs_q :
                        hit_baud ? baud_q : 8'h00;

  assign prdata = prdata_q;
  assign pready = access;
  assign pslverr = access & ~hit;

  // read data caught in setup, held through the zero-wait access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_value};
    end
  end

  // software writable registers; status bits are masked out
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_q <= UAR_RST_FLAGS;
      rcs_q <= UAR_RST_RCS;
      txb_q <= UAR_RST_TXB;
      ien_q <= UAR_RST_IEN;
      txs_q <= UAR_RST_TXS;
      baud_q <= UAR_RST_BAUD;
    end else if (wr_en) begin
      if (hit_flags) flags_q <= wr8(flags_q, pwdata[7:0], UAR_WM_FLAGS);
      if (hit_rcs) rcs_q <= wr8(rcs_q, pwdata[7:0], UAR_WM_RCS);
      if (hit_txb) txb_q <= pwdata[7:0];
      if (hit_ien) ien_q <= wr8(ien_q, pwdata[7:0], UAR_WM_IEN);
      if (hit_txs) txs_q <= wr8(txs_q, pwdata[7:0], UAR_WM_TXS);
      if (hit_baud) baud_q <= pwdata[7:0];
    end
  end

  // gated interrupt request
  assign receive_irq = ready_flag & ien_q[UAR_B_READY];

  // baud generator: tick every baud_q+1 clocks, prescaled by four at low speed
  wire gen_tick = (gen_q == 8'h00);
  wire smp_tick = gen_tick & (high_speed_baud_select | (pre_q == UAR_LOW_PRE));
  always_ff @(posedge clk_sys) begin
    if (rst || !serial_port_enable) begin
      gen_q <= 8'h00;
      pre_q <= 2'b00;
    end else begin
      gen_q <= gen_tick ? baud_q : gen_q - 8'h01;
      if (gen_tick) pre_q <= pre_q + 2'b01;
    end
  end

  // receiver sequencing on sample ticks
  wire rx_fall = rx_prev_q & ~rx_in;
  wire at_dec = smp_tick & (cnt_q == UAR_SMP_C);
  wire at_end = smp_tick & (cnt_q == UAR_LAST);
  wire maj = maj3(s_q[1], s_q[0], rx_in);
  wire [3:0] last_bit = rx9 ? UAR_BITS9 : UAR_BITS8;
  wire rx_done = rx_run & (st_q == UAR_STOP) & at_dec;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    sr_d = sr_q;
    s_d = s_q;
    if (!rx_run) begin
      st_d = UAR_IDLE;
      cnt_d = 4'h0;
    end else begin
      if (st_q != UAR_IDLE && smp_tick) begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == UAR_SMP_A || cnt_q == UAR_SMP_B) begin
          s_d = {s_q[0], rx_in};
        end
      end
      case (st_q)
        UAR_IDLE: begin
          if (rx_fall) begin
            st_d = UAR_START;
            cnt_d = 4'h0;
          end
        end
        UAR_START: begin
          if (at_dec && maj) begin
            st_d = UAR_IDLE;
          end else if (at_end) begin
            st_d = UAR_DATA;
            bit_d = 4'h0;
          end
        end
        UAR_DATA: begin
          if (at_dec) begin
            sr_d = {maj, sr_q[8:1]};
          end
          if (at_end) begin
            bit_d = bit_q + 4'h1;
            if (bit_q == last_bit) begin
              st_d = UAR_STOP;
            end
          end
        end
        UAR_STOP: begin
          if (at_dec) begin
            st_d = UAR_IDLE;
          end
        end
        default: begin
          st_d = UAR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= UAR_IDLE;
      cnt_q <= 4'h0;
      bit_q <= 4'h0;
      sr_q <= 9'h000;
      s_q <= 2'b00;
      rx_prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sr_q <= sr_d;
      s_q <= s_d;
      rx_prev_q <= rx_in;
    end
  end

  // hand-off into the fifo, overrun check first
  wire ovr_set = rx_done & ~overrun_error_q & fifo_full;
  wire push = rx_done & ~overrun_error_q & ~fifo_full;
  uar_entry_t wentry;
  assign wentry.framing_error = ~maj;
  assign wentry.ninth = rx9 ? sr_q[8] : 1'b0;
  assign wentry.data = rx9 ? sr_q[7:0] : sr_q[8:1];

  // overrun sticks until receive reset; a new set wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overrun_error_q <= 1'b0;
    end else begin
      overrun_error_q <= ovr_set | (overrun_error_q & rx_run);
    end
  end

  // fifo storage; a push and a pop may share a cycle
  always_ff @(posedge clk_sys) begin
    if (push) mem[wptr_q] <= wentry;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wptr_q <= wptr_q + 1'b1;
      if (pop) rptr_q <= rptr_q + 1'b1;
      count_q <= count_q + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end
  end

  // pin drive: clock line for sync master, data only while not receiving
  wire sck_drive = serial_port_enable & sync_mode & clock_source_select;
  wire dt_drive = serial_port_enable & sync_mode & txen & ~(continuous_receive_enable | sren);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_q <= 4'h0;
      sck_out_q <= 1'b1;
      dt_out_q <= 1'b1;
    end else begin
      if (smp_tick) sck_q <= sck_q + 4'h1;
      sck_out_q <= sck_q[3];
      dt_out_q <= tx_serial_data;
    end
  end
  assign serial_clock_line_out = sck_out_q;
  assign serial_clock_line_oe_n = ~sck_drive;
  assign serial_data_line_out = dt_out_q;
  assign serial_data_line_oe_n = ~dt_drive;

  // fifo and flag checks
  ready_after_push_a: assert property (@(posedge clk_sys) disable iff (rst)
    push |=> ready_flag)
    else $error("ready flag not set after push");
  push_count_a: assert property (@(posedge clk_sys) disable iff (rst)
    push && !pop |=> count_q == $past(count_q) + 1)
    else $error("push did not add one word");
  ready_fall_pop_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(ready_flag) |-> $past(pop) && $past(count_q) == 1)
    else $error("ready flag fell without last read");
  irq_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
    receive_irq |-> ien_q[UAR_B_READY] && count_q != 0)
    else $error("irq without enable or data");
  fifo_bound_a: assert property (@(posedge clk_sys) disable iff (rst)
    count_q <= FIFO_DEPTH)
    else $error("fifo count above depth");
  pop_advance_a: assert property (@(posedge clk_sys) disable iff (rst)
    pop && !push |=> count_q == $past(count_q) - 1 && rptr_q != $past(rptr_q))
    else $error("read did not advance the fifo");
  ninth_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    push && !rx9 |=> !mem[$past(wptr_q)].ninth)
    else $error("ninth bit stored in eight bit mode");
  frame_err_a: assert property (@(posedge clk_sys) disable iff (rst)
    push && !rx_in && !s_q[0] |=> mem[$past(wptr_q)].framing_error)
    else $error("low stop bit not flagged");

  // overrun checks
  overrun_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx_done && fifo_full && !pop |=> overrun_error_q && $stable(count_q))
    else $error("overrun not flagged or word kept");
  overrun_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(overrun_error_q) |-> !$past(rx_run))
    else $error("overrun cleared early");
  overrun_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    overrun_error_q && rx_run |=> overrun_error_q)
    else $error("overrun lost while receiving");
  overrun_block_a: assert property (@(posedge clk_sys) disable iff (rst)
    overrun_error_q |-> !push)
    else $error("push while overrun");

  // receiver sequencing checks
  rx_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    !rx_run |=> st_q == UAR_IDLE)
    else $error("receiver ran while disabled");
  start_enter_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx_run && st_q == UAR_IDLE && rx_fall |=> st_q == UAR_START && cnt_q == 4'h0)
    else $error("falling edge did not start a frame");
  start_abort_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx_run && st_q == UAR_START && at_dec && maj |=> st_q == UAR_IDLE)
    else $error("false start not abandoned");
  stop_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
    rx_run && at_end && st_q == UAR_DATA && bit_q == last_bit |=> st_q == UAR_STOP)
    else $error("stop bit not reached after last data bit");

  // pin checks
  clk_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
    !serial_clock_line_oe_n |-> serial_port_enable && sync_mode && clock_source_select)
    else $error("clock driven outside master mode");

  // main scenarios reached
  fill_two_c: cover property (@(posedge clk_sys) disable iff (rst) fifo_full);
  overrun_c: cover property (@(posedge clk_sys) disable iff (rst) ovr_set);
  frame_err_c: cover property (@(posedge clk_sys) disable iff (rst) push && wentry.framing_error);
  drain_c: cover property (@(posedge clk_sys) disable iff (rst) $fell(ready_flag));
  nine_bit_c: cover property (@(posedge clk_sys) disable iff (rst) push && rx9);
endmodule
`default_nettype wire

// [tb/uar_line_model.sv]
// far-end serial transmitter driving the receive line
// assumes tasks are entered just after a rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module uar_line_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_sys,
  output logic rx_line
);
  // line rests high between frames
  initial rx_line = 1'b1;

  // hold one level for a whole bit time
  task automatic drive(input logic b);
    rx_line <= b;
    repeat (BIT_CLKS) @(posedge clk_sys);
  endtask

  // start, data lsb first, stop, then one idle bit
  task automatic send(input logic [8:0] w, input int nbits, input logic stop);
    int i;
    drive(1'b0);
    for (i = 0; i < nbits; i++) begin
      drive(w[i]);
    end
    drive(stop);
    drive(1'b1);
  endtask

  // short low pulse that is no real start bit
  task automatic glitch(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge clk_sys);
    drive(1'b1);
    drive(1'b1);
  endtask
endmodule
`default_nettype wire

// [tb/usart_async_receiver_tb.sv]
// self-checking bench for the async receive path
// assumes zero-wait APB slave and x16 ticks at one tick per clock
`timescale 1ns/1ps
`default_nettype none
module usart_async_receiver_tb
  import uar_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, rx_line, clk_oe_n, dat_oe_n, irq;
  logic clk_out, dat_out;
  logic tx_bit = 1'b0;
  int errors = 0;
  int num_checks = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  uar_receiver uar_receiver_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_line),
    .tx_serial_data(tx_bit), .serial_clock_line_out(clk_out),
    .serial_clock_line_oe_n(clk_oe_n), .serial_data_line_out(dat_out),
    .serial_data_line_oe_n(dat_oe_n), .receive_irq(irq));

  uar_line_model uar_line_model_i (.clk_sys(clk_sys), .rx_line(rx_line));

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      conclude();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    @(posedge clk_sys); // written value settles before outputs are looked at
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [7:0] exp, input string m);
    logic [7:0] d;
    logic e;
    apb(1'b0, idx, 8'h00, d, e);
    chk(d, exp, m);
  endtask

  // reset values, unmapped access, read-only and reserved bits
  task automatic t_reset();
    logic [7:0] d;
    logic e;
    rchk(UAR_IDX_FLAGS, UAR_RST_FLAGS, "flags reset");
    rchk(UAR_IDX_RCS, UAR_RST_RCS, "rcs reset");
    rchk(UAR_IDX_TXB, UAR_RST_TXB, "txbuf reset");
    rchk(UAR_IDX_RXD, 8'h00, "rxdata reset");
    rchk(UAR_IDX_IEN, UAR_RST_IEN, "ien reset");
    rchk(UAR_IDX_TXS, UAR_RST_TXS, "txs reset");
    rchk(UAR_IDX_BAUD, UAR_RST_BAUD, "baud reset");
    apb(1'b0, 10'h3FF, 8'h00, d, e);
    chk({7'h00, e}, 8'h01, "unmapped error");
    wr(UAR_IDX_FLAGS, 8'hBF);
    rchk(UAR_IDX_FLAGS, 8'h9F, "ready flag not writable");
    wr(UAR_IDX_FLAGS, 8'h00);
    wr(UAR_IDX_IEN, 8'hBF);
    rchk(UAR_IDX_IEN, 8'hBF, "reserved enable");
    wr(UAR_IDX_IEN, 8'h00);
  endtask

  // one word, flag, interrupt gating and clear on empty
  task automatic t_basic();
    wr(UAR_IDX_BAUD, 8'h00);
    wr(UAR_IDX_TXS, 8'h04);
    wr(UAR_IDX_RCS, 8'h80);
    wr(UAR_IDX_IEN, 8'h20);
    wr(UAR_IDX_RCS, 8'h90);
    uar_line_model_i.send(9'h0A5, 8, 1'b1);
    rchk(UAR_IDX_FLAGS, 8'h20, "ready after word");
    chk({7'h00, irq}, 8'h01, "irq enabled");
    wr(UAR_IDX_IEN, 8'h00);
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(UAR_IDX_IEN, 8'h20);
    rchk(UAR_IDX_RCS, 8'h90, "no errors");
    rchk(UAR_IDX_RXD, 8'hA5, "data lsb first");
    rchk(UAR_IDX_FLAGS, 8'h00, "ready cleared");
    chk({7'h00, irq}, 8'h00, "irq cleared");
  endtask

  // nine bits, framing error per entry, status before data
  task automatic t_ninth();
    wr(UAR_IDX_RCS, 8'hC0);
    wr(UAR_IDX_RCS, 8'hD0);
    uar_line_model_i.send(9'h155, 9, 1'b0);
    uar_line_model_i.send(9'h03A, 9, 1'b1);
    rchk(UAR_IDX_RCS, 8'hD5, "framing_error and ninth head");
    rchk(UAR_IDX_RXD, 8'h55, "first data");
    rchk(UAR_IDX_RCS, 8'hD0, "status advanced");
    rchk(UAR_IDX_RXD, 8'h3A, "second data");
    wr(UAR_IDX_RCS, 8'h90);
  endtask

  // third word overruns, blocked transfers, receive reset
  task automatic t_overrun();
    uar_line_model_i.send(9'h011, 8, 1'b1);
    uar_line_model_i.send(9'h022, 8, 1'b1);
    uar_line_model_i.send(9'h033, 8, 1'b1);
    rchk(UAR_IDX_RCS, 8'h92, "overrun set");
    wr(UAR_IDX_RCS, 8'h90);
    rchk(UAR_IDX_RCS, 8'h92, "overrun not writable");
    uar_line_model_i.send(9'h044, 8, 1'b1);
    rchk(UAR_IDX_RXD, 8'h11, "fifo word one");
    rchk(UAR_IDX_RXD, 8'h22, "fifo word two");
    rchk(UAR_IDX_FLAGS, 8'h00, "no transfer in overrun");
    wr(UAR_IDX_RCS, 8'h80);
    wr(UAR_IDX_RCS, 8'h90);
    rchk(UAR_IDX_RCS, 8'h90, "overrun cleared");
  endtask

  // receive enable and false start
  task automatic t_gate();
    wr(UAR_IDX_RCS, 8'h80);
    uar_line_model_i.send(9'h05A, 8, 1'b1);
    rchk(UAR_IDX_FLAGS, 8'h00, "disabled receiver");
    wr(UAR_IDX_RCS, 8'h90);
    uar_line_model_i.glitch(3);
    rchk(UAR_IDX_FLAGS, 8'h00, "false start dropped");
  endtask

  // synchronous master pins, clock line, data line and half duplex
  task automatic t_sync();
    logic c;
    int n;
    wr(UAR_IDX_TXS, 8'h90);
    chk({7'h00, clk_oe_n}, 8'h00, "master drives clock");
    c = clk_out;
    n = 0;
    while (clk_out === c && n < 64) begin
      @(posedge clk_sys);
      n++;
    end
    chk({7'h00, clk_out ^ c}, 8'h01, "clock line toggles");
    uar_line_model_i.send(9'h066, 8, 1'b1);
    rchk(UAR_IDX_FLAGS, 8'h00, "async receiver off");
    wr(UAR_IDX_TXS, 8'hB0);
    chk({7'h00, dat_oe_n}, 8'h01, "no transmit while receiving");
    wr(UAR_IDX_RCS, 8'h80);
    chk({7'h00, dat_oe_n}, 8'h00, "transmit drives data");
    tx_bit <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({7'h00, dat_out}, 8'h01, "data line follows transmit");
    wr(UAR_IDX_TXS, 8'h30);
    chk({7'h00, clk_oe_n}, 8'h01, "slave clock released");
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_basic();
    t_ninth();
    t_overrun();
    t_gate();
    t_sync();
    conclude();
  end
endmodule
`default_nettype wire
